// file: hdl/pscr_pkg.sv
// Constants, field layouts and carrier types for the serial reconfiguration chain.
// Assumes one pclk domain; the chain pins arrive asynchronously from core logic.
package pscr_pkg;
    localparam int CHAIN_LEN = 144;
    localparam int DIV_NUM   = 7;
    localparam int CNT_W     = 8;
    localparam int HALF_W    = 9;
    localparam int SET_W     = 9;
    localparam int ACT_WORDS = 5;

    // Register byte offsets
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_MASK   = 8'h08;
    localparam logic [7:0] ADDR_INFO   = 8'h0c;
    localparam logic [7:0] ADDR_ACT0   = 8'h10;

    // Status, mask and info field positions
    localparam int ST_APPLY  = 0;
    localparam int ST_FULL   = 1;
    localparam int ST_OVER   = 2;
    localparam int ST_W      = 3;
    localparam int INFO_BUSY = 8;
    localparam int INFO_SHEN = 9;

    // Reset values and the bit counter saturation value
    localparam logic        CTRL_RUN_RST = 1'b1;
    localparam logic [2:0]  MASK_RST     = 3'h0;
    localparam logic [7:0]  BITCNT_MAX   = 8'hff;

    // One divider field, first-shifted bit at the bottom
    typedef struct packed {
        logic             odd;
        logic [CNT_W-1:0] high;
        logic             bypass;
        logic [CNT_W-1:0] low;
    } pscr_div_field_t;

    // Whole chain; div[0] is the last post-scale counter, div[5] feedback, div[6] pre-scale
    typedef struct packed {
        logic [SET_W-1:0]              filter;
        logic [SET_W-1:0]              pump;
        pscr_div_field_t [DIV_NUM-1:0] div;
    } pscr_chain_t;

    // Chain pins as one group
    typedef struct packed {
        logic clk;
        logic shift_en;
        logic data;
        logic apply;
    } pscr_scan_pins_t;
endpackage

// file: hdl/pscr_top.sv
// Serial reconfiguration chain, active divider settings, divider counters and APB registers.
// Assumes chain pins come from core logic asynchronously; pclk stands for half a VCO cycle.
`timescale 1ns/100ps

// Rules for this block and its controller
// RULE_01: Chain is 144 bits, one bit per edge
// RULE_02: Controller keeps serial clock at most 100 MHz
// RULE_03: Controller raises enable a cycle before data
// RULE_04: First bit taken on second edge after enable
// RULE_05: Controller drops enable after 144 bits
// RULE_06: Apply pulse copies chain into active settings
// RULE_07: Busy high while reconfiguring, falls when done
// RULE_08: Each counter adopts at its own period end
// RULE_09: Controller resets loop after divider changes
// RULE_10: Unlimited repeated load and apply sequences
// RULE_11: Chain never changes counter phase offsets
// RULE_12: Eight-bit high and low counts set period
// RULE_13: Each divider field is eighteen chain bits
// RULE_14: Bypass set divides by one
// RULE_15: Odd clear: output falls on rising edge
// RULE_16: Odd set: fall on falling edge, half shifted
// RULE_17: First bit is last counter low LSB
// RULE_18: Bypass set ignores other count bits
// RULE_19: Chain shifts only while enable high
module pscr_top
(
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [7:0]                 paddr,
    input  wire logic [31:0]                pwdata,
    output logic                            pready,
    output logic [31:0]                     prdata,
    output logic                            pslverr,
    output logic                            irq,
    input  wire pscr_pkg::pscr_scan_pins_t  scan_pins,
    output logic                            apply_busy,
    output logic [pscr_pkg::DIV_NUM-1:0]    div_clk,
    output logic [pscr_pkg::SET_W-1:0]      pump_current_setting,
    output logic [pscr_pkg::SET_W-1:0]      filter_setting
);
    import pscr_pkg::*;

    // Half-cycle length of one phase; a zero length clamps to one half-cycle (zero high count with odd set wraps to 511)
    function automatic logic [HALF_W-1:0] half_len(input pscr_div_field_t f, input logic hi);
        logic [HALF_W-1:0] n;
        if (hi)
            n = {f.high, 1'b0} - {{(HALF_W-1){1'b0}}, f.odd};  // [RULE_16]
        else
            n = {f.low, 1'b0} + {{(HALF_W-1){1'b0}}, f.odd};   // [RULE_16]
        if (n == '0)
            n = {{(HALF_W-1){1'b0}}, 1'b1};
        return n;
    endfunction

    // Synchroniser and chain state
    pscr_scan_pins_t     sync1_q, sync2_q, prev_q;
    logic                en_seen_q, en_seen_d;
    logic                app_seen_q, app_seen_d;
    pscr_chain_t         chain_q, chain_d;
    logic [7:0]          bitcnt_q, bitcnt_d;
    pscr_chain_t         act_q, act_d;
    logic                busy_q, busy_d;
    logic                ev_full, ev_over, ev_apply, ev_done;
    logic                scan_rise;

    // Counter state
    logic [DIV_NUM-1:0]  hi_q, hi_d;
    logic [DIV_NUM-1:0]  pend_q, pend_d;
    logic [HALF_W-1:0]   cnt_q [DIV_NUM];
    logic [HALF_W-1:0]   cnt_d [DIV_NUM];
    pscr_div_field_t     cfg_q [DIV_NUM];
    pscr_div_field_t     cfg_d [DIV_NUM];

    // Register state
    logic                run_q, run_d;
    logic [ST_W-1:0]     stat_q, stat_d;
    logic [ST_W-1:0]     mask_q, mask_d;
    logic                pready_q, pready_d;
    logic                pslverr_q, pslverr_d;
    logic [31:0]         prdata_q, prdata_d;
    logic                irq_q, irq_d;

    assign scan_rise = sync2_q.clk & ~prev_q.clk;

    // Chain shifting and apply; enable sampled on one edge, shifting from the next
    always_comb
    begin
        en_seen_d = en_seen_q;
        app_seen_d = app_seen_q;
        chain_d   = chain_q;
        bitcnt_d  = bitcnt_q;
        act_d     = act_q;
        ev_full   = 1'b0;
        ev_over   = 1'b0;
        ev_apply  = 1'b0;
        if (scan_rise)
        begin
            en_seen_d = sync2_q.shift_en;                               // [RULE_04]
            if (en_seen_q && sync2_q.shift_en)                          // [RULE_19]
            begin
                // New bit enters at the top so the first one ends at bit 0
                chain_d = {sync2_q.data, chain_q[CHAIN_LEN-1:1]};       // [RULE_01] [RULE_17]
                if (bitcnt_q != BITCNT_MAX)
                    bitcnt_d = bitcnt_q + 8'h01;
                ev_full = (bitcnt_q == 8'(CHAIN_LEN - 1));
                ev_over = (bitcnt_q >= 8'(CHAIN_LEN));
            end
            else if (!sync2_q.shift_en)
                bitcnt_d = 8'h00;                                       // [RULE_10]
            // Apply edge judged between serial edges, not pclk cycles
            app_seen_d = sync2_q.apply;
            if (sync2_q.apply && !app_seen_q)
            begin
                act_d    = chain_q;                                     // [RULE_06] [RULE_13]
                ev_apply = 1'b1;
            end
        end
    end

    // Synchronisers feed only the next stage; chain registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync1_q   <= '0;
            sync2_q   <= '0;
            prev_q    <= '0;
            en_seen_q <= 1'b0;
            app_seen_q <= 1'b0;
            chain_q   <= '0;
            bitcnt_q  <= 8'h00;
            act_q     <= '0;
        end
        else
        begin
            sync1_q   <= scan_pins;
            sync2_q   <= sync1_q;
            prev_q    <= sync2_q;
            en_seen_q <= en_seen_d;
            app_seen_q <= app_seen_d;
            chain_q   <= chain_d;
            bitcnt_q  <= bitcnt_d;
            act_q     <= act_d;
        end
    end

    // Divider counters; each takes new settings at the end of its own low phase, or at once while stopped
    always_comb
    begin
        logic boundary;
        boundary = 1'b0;
        hi_d     = hi_q;
        pend_d   = pend_q;
        busy_d   = busy_q;
        ev_done  = 1'b0;
        for (int i = 0; i < DIV_NUM; i++)
        begin
            cnt_d[i] = cnt_q[i];
            cfg_d[i] = cfg_q[i];
            boundary = ~hi_q[i] & (cfg_q[i].bypass | (cnt_q[i] == HALF_W'(1)));
            if (!run_q)
            begin
                // Stopped counters have no period end to wait for
                if (pend_q[i])
                begin
                    cfg_d[i]  = act_q.div[i];
                    pend_d[i] = 1'b0;
                    cnt_d[i]  = half_len(act_q.div[i], 1'b1);
                    hi_d[i]   = 1'b1;
                end
            end
            else if (boundary)
            begin
                // Only the divide ratio changes here; counting continues in step
                if (pend_q[i])                                          // [RULE_08] [RULE_11]
                begin
                    cfg_d[i]  = act_q.div[i];
                    pend_d[i] = 1'b0;
                end
                hi_d[i]  = 1'b1;
                cnt_d[i] = half_len(pend_q[i] ? act_q.div[i] : cfg_q[i], 1'b1);  // [RULE_12]
            end
            else if (cfg_q[i].bypass)
                hi_d[i] = 1'b0;                                         // [RULE_14] [RULE_18]
            else if (cnt_q[i] == HALF_W'(1))
            begin
                // Even lengths end on a VCO rising edge, odd ones on a falling edge
                hi_d[i]  = 1'b0;                                        // [RULE_15] [RULE_16]
                cnt_d[i] = half_len(cfg_q[i], 1'b0);                    // [RULE_12]
            end
            else
                cnt_d[i] = cnt_q[i] - HALF_W'(1);
        end
        // Fresh apply re-arms every counter and wins over completion
        if (ev_apply)
        begin
            pend_d = '1;                                                // [RULE_06]
            busy_d = 1'b1;                                              // [RULE_07]
        end
        else if (busy_q && pend_q == '0)
        begin
            busy_d  = 1'b0;                                             // [RULE_07]
            ev_done = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            hi_q   <= '0;
            pend_q <= '0;
            busy_q <= 1'b0;
            for (int i = 0; i < DIV_NUM; i++)
            begin
                cnt_q[i] <= HALF_W'(1);
                cfg_q[i] <= '0;
            end
        end
        else
        begin
            hi_q   <= hi_d;
            pend_q <= pend_d;
            busy_q <= busy_d;
            for (int i = 0; i < DIV_NUM; i++)
            begin
                cnt_q[i] <= cnt_d[i];
                cfg_q[i] <= cfg_d[i];
            end
        end
    end

    // APB slave: no wait states, read data captured in setup, writes land at completion
    always_comb
    begin
        logic             wr;
        logic [ST_W-1:0]  ev;
        logic [3:0]       widx;
        logic [CHAIN_LEN+15:0] act_pad;
        wr       = psel & penable & pready_q & pwrite;
        ev       = '0;
        widx     = 4'(paddr[7:2] - ADDR_ACT0[7:2]);
        act_pad  = {16'h0000, act_q};
        run_d    = run_q;
        mask_d   = mask_q;
        stat_d   = stat_q;
        pready_d = psel & ~penable;
        pslverr_d = 1'b0;
        prdata_d  = prdata_q;
        ev[ST_APPLY] = ev_done;
        ev[ST_FULL]  = ev_full;
        ev[ST_OVER]  = ev_over;
        if (psel && !penable)
        begin
            prdata_d = 32'h0000_0000;
            unique case (paddr)
                ADDR_CTRL:   prdata_d[0] = run_q;
                ADDR_STATUS: prdata_d[ST_W-1:0] = stat_q;
                ADDR_MASK:   prdata_d[ST_W-1:0] = mask_q;
                ADDR_INFO:   prdata_d = {22'h0, sync2_q.shift_en, busy_q, bitcnt_q};
                default:
                begin
                    if (paddr >= ADDR_ACT0 && widx < 4'(ACT_WORDS) && paddr[1:0] == 2'b00)
                        prdata_d = act_pad[widx*32 +: 32];
                    else
                        pslverr_d = 1'b1;
                end
            endcase
        end
        else if (psel && penable)
            pslverr_d = pslverr_q;
        if (wr && paddr == ADDR_CTRL)
            run_d = pwdata[0];
        if (wr && paddr == ADDR_MASK)
            mask_d = pwdata[ST_W-1:0];
        // Write-one clears, but a same-cycle event keeps its bit
        if (wr && paddr == ADDR_STATUS)
            stat_d = stat_q & ~pwdata[ST_W-1:0];
        stat_d = stat_d | ev;
        irq_d  = |(stat_d & mask_d);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            run_q     <= CTRL_RUN_RST;
            mask_q    <= MASK_RST;
            stat_q    <= '0;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
            irq_q     <= 1'b0;
        end
        else
        begin
            run_q     <= run_d;
            mask_q    <= mask_d;
            stat_q    <= stat_d;
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
            prdata_q  <= prdata_d;
            irq_q     <= irq_d;
        end
    end

    // Outputs straight from flip-flops
    assign pready               = pready_q;
    assign prdata               = prdata_q;
    assign pslverr              = pslverr_q;
    assign irq                  = irq_q;
    assign apply_busy           = busy_q;
    assign div_clk              = hi_q;
    assign pump_current_setting = act_q.pump;
    assign filter_setting       = act_q.filter;
endmodule

// file: sim/pscr_top_chk.sv
// Port checker for the reconfiguration block.
// Assumes one pclk domain; bound onto every pscr_top.
`timescale 1ns/100ps
module pscr_top_chk
(
    input wire logic                         pclk,
    input wire logic                         presetn,
    input wire logic                         psel,
    input wire logic                         penable,
    input wire logic                         pwrite,
    input wire logic [7:0]                   paddr,
    input wire logic                         pready,
    input wire logic [31:0]                  prdata,
    input wire logic                         pslverr,
    input wire pscr_pkg::pscr_scan_pins_t    scan_pins,
    input wire logic                         apply_busy,
    input wire logic [pscr_pkg::SET_W-1:0]   pump_current_setting,
    input wire logic [pscr_pkg::SET_W-1:0]   filter_setting
);
    logic [5:0]  ap_q, ap_d;
    logic [11:0] bz_q, bz_d;
    logic        ok_addr;
    // Ages of the apply pin and of busy; apply age saturates, busy age clears when busy drops but can wrap
    always_comb
    begin
        ap_d = scan_pins.apply ? 6'h00 : ap_q + {5'h00, ap_q != 6'h3f};
        bz_d = apply_busy ? bz_q + 12'h001 : 12'h000;
        ok_addr = paddr[1:0] == 2'h0 && paddr <= 8'h20;
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ap_q <= 6'h3f;
            bz_q <= 12'h000;
        end
        else
        begin
            ap_q <= ap_d;
            bz_q <= bz_d;
        end
    end
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // Setup then access; the answer belongs to the first access cycle
    sequence s_setup_access;
        psel && !penable ##1 psel && penable;
    endsequence
    a_ready_first_access: assert property (s_setup_access |-> pready)
        else $error("pready late");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("pready held");
    a_err_reads_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
        else $error("error read not zero");
    a_bad_addr_err: assert property (pready && !ok_addr |-> pslverr)
        else $error("unmapped address accepted");
    a_good_addr_ok: assert property (pready && ok_addr |-> !pslverr)
        else $error("mapped address refused");
    a_settings_on_apply: assert property
        (!$stable({pump_current_setting, filter_setting}) |-> ##[0:1] apply_busy)
        else $error("settings moved without apply");
    a_busy_after_apply: assert property ($rose(apply_busy) |-> ap_q < 6'h10)
        else $error("busy without apply");
    a_busy_bounded: assert property (apply_busy |-> bz_q < 12'h44c)
        else $error("busy too long");
endmodule
bind pscr_top pscr_top_chk u_chk
(
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .scan_pins(scan_pins), .apply_busy(apply_busy),
    .pump_current_setting(pump_current_setting), .filter_setting(filter_setting)
);

// file: sim/pscr_ctl_model.sv
// Controller model driving the chain pins of the block.
// Assumes pclk from the bench; the serial clock stands still outside a load.
`timescale 1ns/100ps
module pscr_ctl_model
(
    input wire logic                  pclk,
    output pscr_pkg::pscr_scan_pins_t pins
);
    import pscr_pkg::*;
    initial pins = '0;
    // Half a serial period is 4 pclk: 31.25 MHz, under the ceiling
    task automatic half(input logic c);
        pins.clk <= c;
        repeat (4) @(posedge pclk);
    endtask
    task automatic cyc;
        half(1'b0);
        half(1'b1);
    endtask
    // Loop reset and phase steps are left to other logic
    task automatic load(input pscr_chain_t w);
        pins.shift_en <= 1'b1;
        cyc();
        for (int i = 0; i < CHAIN_LEN; i++)
        begin
            pins.data <= w[i];
            cyc();
        end
        pins.shift_en <= 1'b0;
        pins.data <= ~w[CHAIN_LEN-1];
        cyc();
        pins.apply <= 1'b1;
        cyc();
        pins.apply <= 1'b0;
        half(1'b0);
    endtask
endmodule

// file: sim/test_pscr_top.sv
// Bench for the block: decode, two chain loads, divider outputs, interrupt.
// Assumes the controller model on the chain pins and the bound checker.
`timescale 1ns/100ps
module test_pscr_top;
    import pscr_pkg::*;
    logic               pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, busy, er;
    logic [7:0]         paddr;
    logic [31:0]        pwdata, prdata, rd;
    logic [DIV_NUM-1:0] div_clk;
    logic [SET_W-1:0]   pump, filt;
    pscr_scan_pins_t    pins;
    pscr_chain_t        w;
    int                 fail_count, check_count, h, l, k;
    // Rows: address, reset value of bit 0, error expected
    localparam logic [9:0] ROW [8] = '{10'h002, 10'h010, 10'h020, 10'h030, 10'h040, 10'h080, 10'h091, 10'h009};
    pscr_top DUT
    (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .irq(irq),
        .scan_pins(pins), .apply_busy(busy), .div_clk(div_clk), .pump_current_setting(pump),
        .filter_setting(filt)
    );
    pscr_ctl_model ctl (.pclk(pclk), .pins(pins));
    initial
    begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            fail_count++;
        end
    endtask
    // A wait that ran out ends the run as a mismatch
    task automatic guard(input int n);
        if (n >= 3000)
        begin
            fail_count++;
            print_verdict();
        end
    endtask
    // One transfer; the request stands until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n++ < 3000) @(posedge pclk);
        rd = prdata; er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        guard(n);
        @(posedge pclk);
    endtask
    task automatic irq_is(input logic e);
        @(negedge pclk);
        chk({31'h0, irq}, {31'h0, e});
        @(posedge pclk);
    endtask
    // Load, wait for adoption, then status, settings and read-only active words
    task automatic load_check(input logic e);
        int n;
        n = 0;
        ctl.load(w);
        @(negedge pclk);
        while (busy !== 1'b0 && n++ < 3000) @(negedge pclk);
        guard(n);
        repeat (2) @(posedge pclk);
        irq_is(e);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(rd, 32'h3);
        chk({23'h0, pump}, {23'h0, w.pump});
        chk({23'h0, filt}, {23'h0, w.filter});
        for (n = 0; n < ACT_WORDS; n++)
        begin
            apb(1'b1, ADDR_ACT0 + 8'(4 * n), 32'hffffffff);
            apb(1'b0, ADDR_ACT0 + 8'(4 * n), 32'h0);
            chk(rd, 32'(w >> (32 * n)));
        end
    endtask
    // One high and one low phase of a divider output, in pclk cycles
    task automatic meas(input int i);
        int n;
        n = 0; h = 0; l = 0;
        @(negedge pclk);
        while (div_clk[i] !== 1'b0 && n++ < 3000) @(negedge pclk);
        while (div_clk[i] !== 1'b1 && n++ < 3000) @(negedge pclk);
        while (div_clk[i] === 1'b1 && h++ < 3000) @(negedge pclk);
        while (div_clk[i] === 1'b0 && l++ < 3000) @(negedge pclk);
        guard(n);
        @(posedge pclk);
    endtask
    initial
    begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
        fail_count = 0; check_count = 0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (k = 0; k < 8; k++)
        begin
            apb(1'b0, ROW[k][9:2], 32'h0);
            chk(rd, {31'h0, ROW[k][1]});
            chk({31'h0, er}, {31'h0, ROW[k][0]});
        end
        w = '0; w.pump = 9'h1a5; w.filter = 9'h0c3;
        w.div[0] = {1'b0, 8'h05, 1'b1, 8'h07};
        w.div[1] = {1'b0, 8'h03, 1'b0, 8'h02};
        w.div[2] = {1'b1, 8'h02, 1'b0, 8'h01};
        apb(1'b1, ADDR_MASK, 32'h1);
        load_check(1'b1);
        meas(1);
        chk(h, 6);
        chk(l, 4);
        meas(2);
        chk(h, 3);
        chk(l, 3);
        // Bypassed counter toggles every cycle despite nonzero counts
        @(negedge pclk);
        for (k = 0; k < 4; k++)
        begin
            h = div_clk[0];
            @(negedge pclk);
            chk({31'h0, div_clk[0]}, {31'h0, ~h[0]});
        end
        @(posedge pclk);
        apb(1'b1, ADDR_STATUS, 32'h3);
        irq_is(1'b0);
        // Second load masked, then unmasked and cleared
        apb(1'b1, ADDR_MASK, 32'h0);
        w.pump = 9'h05a; w.filter = 9'h13c;
        w.div[1] = {1'b0, 8'h04, 1'b0, 8'h04};
        load_check(1'b0);
        meas(1);
        chk(h, 8);
        chk(l, 8);
        apb(1'b1, ADDR_MASK, 32'h1);
        irq_is(1'b1);
        apb(1'b1, ADDR_STATUS, 32'h7);
        irq_is(1'b0);
        print_verdict();
    end
endmodule
